// [obc_top.sv]
/*
  Option byte configuration loader. Holds the option byte, accepts
  programming commands over APB (programming mode only) and latches the
  option values at reset for the device.
  Assumes i_prog_mode comes from a pin and the APB master shares i_clk.
*/
// Implementation choices: the APB slave port and the register offsets.
// Summary of operation
// - Erased option byte reads 8'hff; every option defaults to one.
// - Byte has no processor address; only programming mode accesses it.
// - Bit 5: zero enables watchdog from reset, one leaves it to software.
// - Bit 4: zero disables nested interrupts, one enables them.
// - Bit 3: zero enables low voltage detector and its reset.
// - Bit 1: zero passes 6 MHz oscillator, one divides 12 MHz by two.
// - Bit 0 zero blocks program memory reads and writes.
// - Erasing byte while protected first erases all program memory.
`timescale 1ns/100ps
module obc_top (
  input  wire logic        i_clk,
  input  wire logic        i_sys_rst,
  input  wire logic        i_prog_mode,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  output logic             o_watchdog_hw_enable,
  output logic             o_nested_irq_enable,
  output logic             o_lvd_enable,
  output logic             o_usb_clock_div2,
  output logic             o_readout_protect
);
  typedef enum logic [2:0] {
    OBC_IDLE  = 3'b001,
    OBC_WIPE  = 3'b010,
    OBC_CLEAR = 3'b100
  } obc_state_e;

  obc_mem_if mbus ();

  obc_state_e                        state_ff;
  obc_state_e                        nxt_state;
  logic [7:0]                        opt_ff = obc_pkg::OBC_ERASED_VALUE;
  logic [7:0]                        active_ff;
  logic [7:0]                        data_ff;
  logic [obc_pkg::OBC_MEM_AW-1:0]    wipe_ff;
  logic                              pm_s1_ff;
  logic                              pm_ff;
  logic                              rst_seen_ff;
  logic [31:0]                       prdata_ff;
  logic                              pready_ff;
  logic                              pslverr_ff;
  logic                              wdg_ff;
  logic                              nested_irq_enable_ff;
  logic                              lvd_ff;
  logic                              usb_ff;
  logic                              prot_ff;

  // =========================================================
  // Pin synchroniser
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pm_s1_ff <= 1'b0;
      pm_ff    <= 1'b0;
    end else begin
      pm_s1_ff <= i_prog_mode;
      pm_ff    <= pm_s1_ff;
    end
  end

  // =========================================================
  // APB decode
  // Writes commit at the edge where pready is seen high.
  wire acc      = psel & penable & ~pready_ff;
  wire fin      = psel & penable & pready_ff;
  wire allowed  = pm_ff;
  wire hit_cmd  = paddr == obc_pkg::OBC_OFF_CMD;
  wire hit_data = paddr == obc_pkg::OBC_OFF_DATA;
  wire hit_stat = paddr == obc_pkg::OBC_OFF_STATUS;
  wire hit_act  = paddr == obc_pkg::OBC_OFF_ACTIVE;
  wire mapped   = hit_cmd | hit_data | hit_stat | hit_act;
  wire wr_ok    = fin & pwrite & ~pslverr_ff;
  wire idle     = state_ff == OBC_IDLE;
  wire protect  = ~opt_ff[obc_pkg::OBC_BIT_PROTECT];
  wire cmd_prog = wr_ok & hit_cmd & idle
                  & pwdata[1:0] == obc_pkg::OBC_CMD_PROGRAM;
  wire cmd_erase = wr_ok & hit_cmd & idle
                   & pwdata[1:0] == obc_pkg::OBC_CMD_ERASE;
  wire wr_data  = wr_ok & hit_data;
  wire bad      = ~mapped | ~allowed;
  wire [31:0] rd_mux =
    hit_stat ? {29'h0, protect, ~idle, pm_ff} :
    hit_act  ? {24'h0, active_ff} :
    hit_data ? {24'h0, data_ff} : 32'h0;
  wire        nxt_pslverr = acc & bad;
  wire [31:0] nxt_prdata  = (acc & ~pwrite & ~bad) ? rd_mux : 32'h0;

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      pready_ff  <= 1'b0;
      pslverr_ff <= 1'b0;
      prdata_ff  <= 32'h0;
    end else begin
      pready_ff  <= acc;
      pslverr_ff <= nxt_pslverr;
      prdata_ff  <= nxt_prdata;
    end
  end
  assign prdata  = prdata_ff;
  assign pready  = pready_ff;
  assign pslverr = pslverr_ff;

  // =========================================================
  // Staging data and option byte store
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      data_ff <= 8'h00;
    end else if (wr_data) begin
      data_ff <= pwdata[7:0];
    end
  end

  // Option byte is non-volatile: unaffected by system reset.
  // Programming only clears writable bits; reserved bits stay set.
  always_ff @(posedge i_clk) begin
    if (cmd_prog) begin
      opt_ff <= opt_ff & (data_ff | ~obc_pkg::OBC_WRITABLE_MASK);
    end else if (state_ff == OBC_CLEAR) begin
      opt_ff <= obc_pkg::OBC_ERASED_VALUE;
    end
  end

  // =========================================================
  // Erase sequencer
  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      OBC_IDLE: begin
        if (cmd_erase) begin
          nxt_state = protect ? OBC_WIPE : OBC_CLEAR;
        end
      end
      OBC_WIPE: begin
        if (wipe_ff == obc_pkg::OBC_MEM_AW'(obc_pkg::OBC_MEM_WORDS - 1)) begin
          nxt_state = OBC_CLEAR;
        end
      end
      OBC_CLEAR: begin
        nxt_state = OBC_IDLE;
      end
      default: begin
        nxt_state = OBC_IDLE;
      end
    endcase
  end

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      state_ff <= OBC_IDLE;
      wipe_ff  <= '0;
    end else begin
      state_ff <= nxt_state;
      wipe_ff  <= (state_ff == OBC_WIPE) ? wipe_ff + 1'b1 : '0;
    end
  end

  assign mbus.wr_en = state_ff == OBC_WIPE;
  assign mbus.addr  = wipe_ff;
  assign mbus.wdata = obc_pkg::OBC_ERASED_VALUE;

  obc_mem u_mem (
    .i_clk (i_clk),
    .bus   (mbus)
  );

  // =========================================================
  // Option latch at reset release
  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      rst_seen_ff <= 1'b1;
      active_ff   <= obc_pkg::OBC_ERASED_VALUE;
    end else begin
      rst_seen_ff <= 1'b0;
      if (rst_seen_ff) begin
        active_ff <= opt_ff;
      end
    end
  end

  // =========================================================
  // Option decode from the latched byte
  wire nxt_wdg  = ~active_ff[obc_pkg::OBC_BIT_WDG_SEL];
  wire nxt_nested_irq_enable = active_ff[obc_pkg::OBC_BIT_NESTED_IRQ_ENABLE];
  wire nxt_lvd  = ~active_ff[obc_pkg::OBC_BIT_LVD_SEL];
  wire nxt_usb  = active_ff[obc_pkg::OBC_BIT_USB_DIV];
  wire nxt_prot = ~active_ff[obc_pkg::OBC_BIT_PROTECT];

  always_ff @(posedge i_clk) begin
    if (i_sys_rst) begin
      wdg_ff  <= 1'b0;
      nested_irq_enable_ff <= 1'b1;
      lvd_ff  <= 1'b0;
      usb_ff  <= 1'b1;
      prot_ff <= 1'b0;
    end else begin
      wdg_ff  <= nxt_wdg;
      nested_irq_enable_ff <= nxt_nested_irq_enable;
      lvd_ff  <= nxt_lvd;
      usb_ff  <= nxt_usb;
      prot_ff <= nxt_prot;
    end
  end
  assign o_watchdog_hw_enable = wdg_ff;
  assign o_nested_irq_enable  = nested_irq_enable_ff;
  assign o_lvd_enable         = lvd_ff;
  assign o_usb_clock_div2     = usb_ff;
  assign o_readout_protect    = prot_ff;
endmodule

// [obc_pkg.sv]
/*
  Package of the option byte configuration loader: APB register map,
  option bit positions, reset values and programming commands.
  Assumes a 100 MHz clock and a 32-bit APB bus.
*/
package obc_pkg;
  // =========================================================
  // Option byte layout
  localparam logic [7:0] OBC_ERASED_VALUE   = 8'hff;
  localparam int         OBC_BIT_WDG_SEL    = 5;
  localparam int         OBC_BIT_NESTED_IRQ_ENABLE       = 4;
  localparam int         OBC_BIT_LVD_SEL    = 3;
  localparam int         OBC_BIT_USB_DIV    = 1;
  localparam int         OBC_BIT_PROTECT    = 0;
  localparam logic [7:0] OBC_WRITABLE_MASK  = 8'h3b;
  // =========================================================
  // APB register map, programming port only
  localparam logic [7:0] OBC_OFF_CMD        = 8'h00;
  localparam logic [7:0] OBC_OFF_DATA       = 8'h04;
  localparam logic [7:0] OBC_OFF_STATUS     = 8'h08;
  localparam logic [7:0] OBC_OFF_ACTIVE     = 8'h0c;
  // =========================================================
  // Commands written to the command register
  localparam logic [1:0] OBC_CMD_PROGRAM    = 2'h1;
  localparam logic [1:0] OBC_CMD_ERASE      = 2'h2;
  // =========================================================
  // Program memory erase timing
  localparam int         OBC_MEM_WORDS      = 16;
  localparam int         OBC_MEM_AW         = 4;
endpackage

// [obc_mem_if.sv]
/*
  Interface between the loader and its memory model.
  Assumes one clock shared by both modules.
*/
`timescale 1ns/100ps
interface obc_mem_if;
  logic       wr_en;
  logic [3:0] addr;
  logic [7:0] wdata;
  logic [7:0] rdata;
  modport ctrl (output wr_en, output addr, output wdata, input rdata);
  modport mem  (input wr_en, input addr, input wdata, output rdata);
endinterface

// [obc_mem.sv]
/*
  Small program memory image used to show erase and protection.
  Assumes synchronous write and registered read data.
*/
`timescale 1ns/100ps
module obc_mem (
  input  wire logic i_clk,
  obc_mem_if.mem    bus
);
  logic [7:0] mem_ff [obc_pkg::OBC_MEM_WORDS];
  logic [7:0] rdata_ff;

  // =========================================================
  // Write port and registered read
  always_ff @(posedge i_clk) begin
    if (bus.wr_en) begin
      mem_ff[bus.addr] <= bus.wdata;
    end
    rdata_ff <= mem_ff[bus.addr];
  end
  assign bus.rdata = rdata_ff;
endmodule

// [obc_properties.sv]
/* Port checker of the option byte loader.
   Assumes one clock and a synchronous active-high reset. */
`timescale 1ns/100ps
module obc_properties (
  input wire logic        i_clk,
  input wire logic        i_sys_rst,
  input wire logic        i_prog_mode,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [7:0]  paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  input wire logic        pslverr,
  input wire logic        o_watchdog_hw_enable,
  input wire logic        o_nested_irq_enable,
  input wire logic        o_lvd_enable,
  input wire logic        o_usb_clock_div2,
  input wire logic        o_readout_protect
);
  // ==========
  // Helpers
  wire logic [4:0] outs = {o_watchdog_hw_enable, o_nested_irq_enable,
    o_lvd_enable, o_usb_clock_div2, o_readout_protect};
  wire logic act = pready && !pslverr && !pwrite &&
    paddr == obc_pkg::OBC_OFF_ACTIVE;
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_sys_rst);
  // ==========
  // Properties
  chk_erased_dflt: assert property ($fell(i_sys_rst) |-> outs == 5'h0a)
    else $error("outputs not at erased default");
  chk_refuse_idle: assert property (
    (!i_prog_mode)[*5] ##0 pready |-> pslverr && prdata == 32'h0)
    else $error("access outside programming mode not refused");
  chk_hold_opts: assert property (
    !$past(i_sys_rst) && !$past(i_sys_rst, 2) && !$past(i_sys_rst, 3)
    |-> $stable(outs))
    else $error("options changed without reset");
  chk_wdg_pol: assert property (act |-> o_watchdog_hw_enable != prdata[5])
    else $error("watchdog option polarity");
  chk_nested_irq_enable_pol: assert property (act |-> o_nested_irq_enable == prdata[4])
    else $error("nesting option polarity");
  chk_lvd_pol: assert property (act |-> o_lvd_enable != prdata[3])
    else $error("detector option polarity");
  chk_usb_div: assert property (act |-> o_usb_clock_div2 == prdata[1])
    else $error("usb divider option polarity");
  chk_prot_pol: assert property (act |-> o_readout_protect != prdata[0])
    else $error("protection option polarity");
endmodule
bind obc_top obc_properties chk (
  .i_clk                (i_clk),
  .i_sys_rst            (i_sys_rst),
  .i_prog_mode          (i_prog_mode),
  .psel                 (psel),
  .penable              (penable),
  .pwrite               (pwrite),
  .paddr                (paddr),
  .pwdata               (pwdata),
  .prdata               (prdata),
  .pready               (pready),
  .pslverr              (pslverr),
  .o_watchdog_hw_enable (o_watchdog_hw_enable),
  .o_nested_irq_enable  (o_nested_irq_enable),
  .o_lvd_enable         (o_lvd_enable),
  .o_usb_clock_div2     (o_usb_clock_div2),
  .o_readout_protect    (o_readout_protect)
);

// [obc_tool.sv]
/* Programming tool model: mode pin and APB master.
   Assumes the loader answers on i_clk. */
`timescale 1ns/100ps
module obc_tool (
  input  wire logic        i_clk,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr,
  output logic             o_prog_mode,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [7:0]  paddr,
  output logic      [31:0] pwdata
);
  logic [7:0] rdata;
  logic       err;
  initial begin
    {o_prog_mode, psel, penable, pwrite, paddr, pwdata} = '0;
  end
  // ==========
  // Mode pin, held past the synchroniser
  task automatic mode(input logic m);
    @(posedge i_clk);
    o_prog_mode <= m;
    repeat (3) @(posedge i_clk);
  endtask
  // ==========
  // One APB transfer
  task automatic xfer(input logic w, input logic [7:0] a, d);
    @(posedge i_clk);
    {psel, pwrite, paddr, pwdata} <= {1'b1, w, a, 24'h0, d};
    @(posedge i_clk);
    penable <= 1'b1;
    @(posedge i_clk);
    while (pready !== 1'b1) @(posedge i_clk);
    rdata = prdata[7:0];
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
endmodule

// [tb_top.sv]
/* Self-checking bench of obc_top driven by the tool model.
   Assumes a 100 MHz clock and synchronous reset. */
`timescale 1ns/100ps
module tb_top;
  localparam logic [7:0] stat_off = obc_pkg::OBC_OFF_STATUS;
  localparam logic [7:0] act_off = obc_pkg::OBC_OFF_ACTIVE;
  logic        i_clk = 1'b0;
  logic        i_sys_rst = 1'b1;
  logic        pm, psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  wire  [7:0]  outs;
  int          n_errors = 0;
  int          cmp_count = 0;
  always #5 i_clk = ~i_clk;
  assign outs[7:5] = 3'h0;
  obc_tool t (.i_clk(i_clk), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .o_prog_mode(pm), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  obc_top uut (.i_clk(i_clk), .i_sys_rst(i_sys_rst), .i_prog_mode(pm),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .o_watchdog_hw_enable(outs[4]), .o_nested_irq_enable(outs[3]),
    .o_lvd_enable(outs[2]), .o_usb_clock_div2(outs[1]),
    .o_readout_protect(outs[0]));
  // ==========
  // Helpers
  task automatic chk(input logic [7:0] g, x);
    cmp_count++;
    if (g !== x) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, x);
    end
  endtask
  task automatic rst(input int n);
    i_sys_rst <= 1'b1;
    repeat (n) @(posedge i_clk);
    i_sys_rst <= 1'b0;
    repeat (4) @(posedge i_clk);
  endtask
  task automatic prog(input logic [7:0] b, x);
    logic [7:0] o;
    o = outs;
    t.xfer(1'b1, obc_pkg::OBC_OFF_DATA, b);
    t.xfer(1'b1, obc_pkg::OBC_OFF_CMD, 8'(obc_pkg::OBC_CMD_PROGRAM));
    chk(outs, o);
    rst(2);
    chk(outs, x);
    t.xfer(1'b0, act_off, 8'h00);
    chk(t.rdata, b);
  endtask
  task automatic erase(input logic busy);
    t.xfer(1'b1, obc_pkg::OBC_OFF_CMD, 8'(obc_pkg::OBC_CMD_ERASE));
    t.xfer(1'b0, stat_off, 8'h00);
    chk(8'(t.rdata[1]), 8'(busy));
    chk(8'(t.rdata[2]), 8'(busy));
    chk(8'(t.rdata[0]), 8'h01);
    repeat (8) begin
      if (t.rdata[1]) t.xfer(1'b0, stat_off, 8'h00);
    end
    chk(8'(t.rdata[1]), 8'h00);
    rst(2);
    chk(outs, 8'h0a);
  endtask
  // ==========
  // Scenarios
  task automatic t_refuse();
    t.xfer(1'b0, stat_off, 8'h00);
    chk(8'(t.err), 8'h01);
    chk(t.rdata, 8'h00);
    t.mode(1'b1);
    t.xfer(1'b0, 8'h10, 8'h00);
    chk(8'(t.err), 8'h01);
  endtask
  task automatic t_erased();
    chk(outs, 8'h0a);
    t.xfer(1'b0, act_off, 8'h00);
    chk(t.rdata, obc_pkg::OBC_ERASED_VALUE);
  endtask
  task automatic t_wdg_lvd();
    prog(8'hd7, 8'h1e);
    erase(1'b0);
  endtask
  task automatic t_protect();
    prog(8'hc4, 8'h15);
    erase(1'b1);
  endtask
  task automatic results();
    $display("errors %0d compares %0d", n_errors, cmp_count);
    if (n_errors == 0 && cmp_count > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge i_clk);
    n_errors++;
    results();
  end
  initial begin
    rst(16);
    t_refuse();
    t_erased();
    t_wdg_lvd();
    t_protect();
    results();
  end
endmodule
